//--- hw/mrp_mem_if.sv
// Purpose: Pin-level DRAM/EDO and ROM/Flash sequencer with refresh
// Assumes: Requests held on REQ until REQ_READY; one request at a time
// Notes: Straps are caught on the third clock after reset release
// Behaviour
// - Extra ROM LSB only for 8-bit bank 0
// - Extra bit extends 8-bit ROM to 2 Mbytes
// - ROM bits 9-20 drive lowest twelve address bits
// - Two buffer controls set direction and high-Z
// - Eight column strobes, strobe 0 most significant
// - Flash output enable only during current read
// - Thirteen-bit multiplexed address, bit 0 most significant
// - Address pins double as ROM address bits
// - Read latch enable opens buffer on reads
// - Check bits driven on write, sampled on read
// - Check path enable opens buffer on reads
// - Eight row strobes, one per bank
// - Bank selects access ROM reads, Flash reads/writes
// - Suspend refresh timed by slow external clock
// - Write enable asserted for DRAM/EDO/Flash writes
`timescale 1ns/1ps
module mrp_mem_if (
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire mrp_pkg::mrp_req_t REQ,
    output logic REQ_READY,
    output logic [63:0] RD_CHECK_VALID,
    output logic [7:0] RD_CHECK,
    output logic DONE,
    input wire logic SUSPEND_N,
    input wire logic RTC,
    input wire logic [7:0] CHECK_IN,
    input wire logic FLASH_STRAP_IN,
    input wire logic BANK0_STRAP_IN,
    output mrp_pkg::mrp_pins_t PINS,
    output logic ROM_8BIT,
    output logic ROM_ON_MEM_BUS,
    output logic REFRESH_BUSY
);
    typedef enum logic [2:0] {ST_IDLE, ST_RAS, ST_CAS, ST_PRE, ST_ROM, ST_REF_CAS, ST_REF_RAS} mrp_state_t;

    typedef struct packed {
        mrp_state_t st;
        logic [3:0] tmr;
        logic [11:0] ref_cnt;
        logic ref_pend;
        logic [2:0] rtc_sync;
        logic [1:0] sus_sync;
        logic [1:0] fstrap_sync;
        logic [1:0] bstrap_sync;
        logic [1:0] strap_wait;
        logic strap_done;
        logic rom_8bit;
        logic rom_on_mem;
        mrp_pkg::mrp_req_t cur;
        mrp_pkg::mrp_pins_t pins;
        logic ready;
        logic done;
        logic [7:0] rd_check;
        logic rd_valid;
        logic ref_busy;
    } mrp_st_t;

    mrp_st_t s_reg;
    mrp_st_t s_next;
    logic in_suspend;
    logic rtc_rise;
    logic ref_tick;

    assign in_suspend = ~s_reg.sus_sync[1];
    assign rtc_rise = s_reg.rtc_sync[1] & ~s_reg.rtc_sync[2];
    // Only one tick source is live at a time so the pending flag never misses one
    assign ref_tick = in_suspend ? rtc_rise : (s_reg.ref_cnt == 12'(mrp_pkg::MRP_REF_CYC - 1));

    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        s_next.rd_valid = 1'b0;
        s_next.ready = 1'b0;
        s_next.rtc_sync = {s_reg.rtc_sync[1:0], RTC};
        s_next.sus_sync = {s_reg.sus_sync[0], SUSPEND_N};
        s_next.fstrap_sync = {s_reg.fstrap_sync[0], FLASH_STRAP_IN};
        s_next.bstrap_sync = {s_reg.bstrap_sync[0], BANK0_STRAP_IN};
        if (!s_reg.strap_done) begin
            // Latch only once both sync stages hold the pin level, not their reset value
            if (s_reg.strap_wait == 2'h2) begin
                s_next.strap_done = 1'b1;
                s_next.rom_8bit = s_reg.fstrap_sync[1];
                s_next.rom_on_mem = s_reg.bstrap_sync[1];
            end else begin
                s_next.strap_wait = s_reg.strap_wait + 2'h1;
            end
        end
        if (in_suspend || ref_tick) begin
            s_next.ref_cnt = mrp_pkg::MRP_REF_RESET;
        end else begin
            s_next.ref_cnt = s_reg.ref_cnt + 12'h001;
        end
        if (ref_tick) begin
            s_next.ref_pend = 1'b1;
        end
        if (s_reg.tmr != mrp_pkg::MRP_TMR_RESET) begin
            s_next.tmr = s_reg.tmr - 4'h1;
        end
        unique case (s_reg.st)
            ST_IDLE: begin
                s_next.pins.ras_n = mrp_pkg::MRP_STROBE_IDLE;
                s_next.pins.cas_n = mrp_pkg::MRP_STROBE_IDLE;
                s_next.pins.we_n = 1'b1;
                s_next.pins.check_oe_n = 1'b1;
                s_next.pins.extra_lsb_oe_n = 1'b1;
                s_next.pins.flash_read_enable_n = 1'b1;
                s_next.pins.bank0_sel_n = 1'b1;
                s_next.pins.bank1_sel_n = 1'b1;
                s_next.pins.read_latch_enable_n = 1'b1;
                s_next.pins.check_path_read_en_n = 1'b1;
                s_next.pins.buffer_dir_ctrl = mrp_pkg::MRP_BUF_IDLE;
                if (s_reg.ref_pend || ref_tick) begin
                    // Refresh wins over requests; clear beats set when tick coincides
                    s_next.ref_pend = 1'b0;
                    s_next.ref_busy = 1'b1;
                    s_next.pins.cas_n = 8'h00;
                    s_next.tmr = 4'(mrp_pkg::MRP_CAS_CYC);
                    s_next.st = ST_REF_CAS;
                end else if (REQ.valid && !in_suspend && s_reg.strap_done) begin
                    s_next.cur = REQ;
                    s_next.ready = 1'b1;
                    if (REQ.kind == mrp_pkg::MRP_K_DRAM) begin
                        s_next.pins.addr = REQ.row;
                        s_next.tmr = 4'(mrp_pkg::MRP_RAS_CAS_CYC);
                        s_next.st = ST_RAS;
                    end else begin
                        // Address pins carry bit 0 then 9..20; check pins carry 1..8
                        s_next.pins.addr = {REQ.rom_addr[20], REQ.rom_addr[11:0]};
                        s_next.pins.check_out = REQ.rom_addr[19:12];
                        s_next.pins.check_oe_n = 1'b0;
                        s_next.pins.extra_lsb_oe_n = ~((REQ.kind == mrp_pkg::MRP_K_ROM0) && s_reg.rom_8bit);
                        s_next.pins.bank0_sel_n = ~(REQ.kind == mrp_pkg::MRP_K_ROM0);
                        s_next.pins.bank1_sel_n = ~(REQ.kind == mrp_pkg::MRP_K_ROM1);
                        s_next.pins.we_n = ~REQ.write;
                        s_next.pins.flash_read_enable_n = REQ.write;
                        s_next.pins.buffer_dir_ctrl = REQ.write ? mrp_pkg::MRP_BUF_WRITE : mrp_pkg::MRP_BUF_READ;
                        s_next.tmr = 4'(mrp_pkg::MRP_ROM_CYC);
                        s_next.st = ST_ROM;
                    end
                end
            end
            ST_RAS: begin
                s_next.pins.ras_n = ~(8'h80 >> s_reg.cur.bank);
                if (s_reg.tmr == mrp_pkg::MRP_TMR_RESET) begin
                    s_next.pins.addr = s_reg.cur.col;
                    s_next.pins.cas_n = ~s_reg.cur.byte_en;
                    s_next.pins.we_n = ~s_reg.cur.write;
                    s_next.pins.check_out = s_reg.cur.wr_check;
                    s_next.pins.check_oe_n = ~s_reg.cur.write;
                    s_next.pins.read_latch_enable_n = s_reg.cur.write;
                    s_next.pins.check_path_read_en_n = s_reg.cur.write;
                    s_next.pins.buffer_dir_ctrl = s_reg.cur.write ? mrp_pkg::MRP_BUF_WRITE : mrp_pkg::MRP_BUF_READ;
                    s_next.tmr = 4'(mrp_pkg::MRP_CAS_CYC);
                    s_next.st = ST_CAS;
                end
            end
            ST_CAS: begin
                if (s_reg.tmr == mrp_pkg::MRP_TMR_RESET) begin
                    if (!s_reg.cur.write) begin
                        s_next.rd_check = CHECK_IN;
                        s_next.rd_valid = 1'b1;
                    end
                    s_next.pins.ras_n = mrp_pkg::MRP_STROBE_IDLE;
                    s_next.pins.cas_n = mrp_pkg::MRP_STROBE_IDLE;
                    s_next.pins.we_n = 1'b1;
                    s_next.pins.check_oe_n = 1'b1;
                    s_next.pins.read_latch_enable_n = 1'b1;
                    s_next.pins.check_path_read_en_n = 1'b1;
                    s_next.pins.buffer_dir_ctrl = mrp_pkg::MRP_BUF_IDLE;
                    s_next.done = 1'b1;
                    s_next.tmr = 4'(mrp_pkg::MRP_RAS_PRE_CYC);
                    s_next.st = ST_PRE;
                end
            end
            ST_ROM: begin
                if (s_reg.tmr == mrp_pkg::MRP_TMR_RESET) begin
                    s_next.pins.we_n = 1'b1;
                    s_next.pins.flash_read_enable_n = 1'b1;
                    s_next.pins.bank0_sel_n = 1'b1;
                    s_next.pins.bank1_sel_n = 1'b1;
                    s_next.pins.check_oe_n = 1'b1;
                    s_next.pins.extra_lsb_oe_n = 1'b1;
                    s_next.pins.buffer_dir_ctrl = mrp_pkg::MRP_BUF_IDLE;
                    s_next.done = 1'b1;
                    s_next.st = ST_IDLE;
                end
            end
            ST_REF_CAS: begin
                if (s_reg.tmr == mrp_pkg::MRP_TMR_RESET) begin
                    // CAS-before-RAS refresh of all banks
                    s_next.pins.ras_n = 8'h00;
                    s_next.tmr = 4'(mrp_pkg::MRP_RAS_CAS_CYC);
                    s_next.st = ST_REF_RAS;
                end
            end
            ST_REF_RAS: begin
                if (s_reg.tmr == mrp_pkg::MRP_TMR_RESET) begin
                    s_next.pins.ras_n = mrp_pkg::MRP_STROBE_IDLE;
                    s_next.pins.cas_n = mrp_pkg::MRP_STROBE_IDLE;
                    s_next.ref_busy = 1'b0;
                    s_next.tmr = 4'(mrp_pkg::MRP_RAS_PRE_CYC);
                    s_next.st = ST_PRE;
                end
            end
            ST_PRE: begin
                if (s_reg.tmr == mrp_pkg::MRP_TMR_RESET) begin
                    s_next.st = ST_IDLE;
                end
            end
            default: begin
                s_next.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
            s_reg <= '0;
            s_reg.st <= ST_IDLE;
            s_reg.sus_sync <= 2'h3;
            s_reg.pins.ras_n <= mrp_pkg::MRP_STROBE_IDLE;
            s_reg.pins.cas_n <= mrp_pkg::MRP_STROBE_IDLE;
            s_reg.pins.we_n <= 1'b1;
            s_reg.pins.check_oe_n <= 1'b1;
            s_reg.pins.extra_lsb_oe_n <= 1'b1;
            s_reg.pins.flash_read_enable_n <= 1'b1;
            s_reg.pins.bank0_sel_n <= 1'b1;
            s_reg.pins.bank1_sel_n <= 1'b1;
            s_reg.pins.read_latch_enable_n <= 1'b1;
            s_reg.pins.check_path_read_en_n <= 1'b1;
            s_reg.pins.buffer_dir_ctrl <= mrp_pkg::MRP_BUF_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign PINS = s_reg.pins;
    assign REQ_READY = s_reg.ready;
    assign DONE = s_reg.done;
    assign RD_CHECK = s_reg.rd_check;
    assign RD_CHECK_VALID = {63'h0, s_reg.rd_valid};
    assign ROM_8BIT = s_reg.rom_8bit;
    assign ROM_ON_MEM_BUS = s_reg.rom_on_mem;
    assign REFRESH_BUSY = s_reg.ref_busy;
endmodule

//--- hw/mrp_pkg.sv
// Purpose: Shared constants and types for the memory/ROM pin interface
// Assumes: 125 MHz system clock, all strobes active low at the pins
// Notes: Pin bit 0 is the most significant bit on every bus
package mrp_pkg;
    localparam int MRP_CLK_MHZ = 125;
    localparam int MRP_RAS_PRE_NS = 40;
    localparam int MRP_RAS_PRE_CYC = (MRP_RAS_PRE_NS * MRP_CLK_MHZ + 999) / 1000;
    localparam int MRP_RAS_CAS_NS = 24;
    localparam int MRP_RAS_CAS_CYC = (MRP_RAS_CAS_NS * MRP_CLK_MHZ + 999) / 1000;
    localparam int MRP_CAS_NS = 16;
    localparam int MRP_CAS_CYC = (MRP_CAS_NS * MRP_CLK_MHZ + 999) / 1000;
    localparam int MRP_ROM_NS = 120;
    localparam int MRP_ROM_CYC = (MRP_ROM_NS * MRP_CLK_MHZ + 999) / 1000;
    localparam int MRP_REF_US = 15;
    localparam int MRP_REF_CYC = MRP_REF_US * MRP_CLK_MHZ;
    localparam int MRP_RTC_REF_TICKS = 1;
    localparam logic [7:0] MRP_STROBE_IDLE = 8'hFF;
    localparam logic [1:0] MRP_BUF_IDLE = 2'h3;
    localparam logic [1:0] MRP_BUF_WRITE = 2'h2;
    localparam logic [1:0] MRP_BUF_READ = 2'h1;
    localparam logic [3:0] MRP_TMR_RESET = 4'h0;
    localparam logic [11:0] MRP_REF_RESET = 12'h000;

    typedef enum logic [1:0] {MRP_K_DRAM, MRP_K_ROM0, MRP_K_ROM1} mrp_kind_t;

    typedef struct packed {
        logic valid;
        mrp_kind_t kind;
        logic write;
        logic [2:0] bank;
        logic [12:0] row;
        logic [12:0] col;
        logic [7:0] byte_en;
        logic [20:0] rom_addr;
        logic [7:0] wr_check;
    } mrp_req_t;

    typedef struct packed {
        logic [12:0] addr;
        logic [7:0] ras_n;
        logic [7:0] cas_n;
        logic we_n;
        logic [7:0] check_out;
        logic check_oe_n;
        logic extra_lsb_oe_n;
        logic flash_read_enable_n;
        logic bank0_sel_n;
        logic bank1_sel_n;
        logic read_latch_enable_n;
        logic check_path_read_en_n;
        logic [1:0] buffer_dir_ctrl;
    } mrp_pins_t;
endpackage

//--- sim/mrp_chk.sv
// Purpose: Pin-level property checks for the memory/ROM sequencer
// Assumes: One clock domain, synchronous active-low reset
// Notes: Refresh cadence is bounded with slack for a running access
`timescale 1ns/1ps
module mrp_chk (
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic SUSPEND_N,
    input wire mrp_pkg::mrp_pins_t PINS,
    input wire logic ROM_8BIT,
    input wire logic REFRESH_BUSY
);
    localparam int GAP_MAX = mrp_pkg::MRP_REF_CYC + 40;
    logic [11:0] gap_reg;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    // Slack covers one access that holds off a due refresh
    always_ff @(posedge CLK_SYS) begin
        gap_reg <= (!RSTN || REFRESH_BUSY || !SUSPEND_N) ? 12'h000 : gap_reg + 12'h001;
    end
    ref_gap_a: assert property (gap_reg < GAP_MAX) else $error("refresh overdue");
    ext_lsb_a: assert property (!PINS.extra_lsb_oe_n |-> ROM_8BIT && !PINS.bank0_sel_n && PINS.bank1_sel_n)
        else $error("extra ROM bit outside 8-bit bank 0");
    flash_rd_a: assert property (!PINS.flash_read_enable_n |-> PINS.we_n && (PINS.bank0_sel_n != PINS.bank1_sel_n))
        else $error("flash enable outside a read");
    bank_sel_a: assert property (!(PINS.bank0_sel_n && PINS.bank1_sel_n) |->
        PINS.bank0_sel_n != PINS.bank1_sel_n && PINS.cas_n == 8'hFF) else $error("bank selects clash");
    rd_latch_a: assert property (!PINS.read_latch_enable_n |-> PINS.we_n) else $error("latch open on write");
    chk_path_a: assert property (!PINS.check_path_read_en_n |-> PINS.we_n && PINS.check_oe_n)
        else $error("check path read while driving");
    wr_drive_a: assert property (!PINS.we_n && PINS.cas_n != 8'hFF |->
        !PINS.check_oe_n && PINS.buffer_dir_ctrl == mrp_pkg::MRP_BUF_WRITE) else $error("write not driven");
    ras_one_a: assert property (PINS.ras_n != 8'hFF |-> $onehot(~PINS.ras_n) || PINS.ras_n == 8'h00)
        else $error("several row strobes");
    cas_row_a: assert property (PINS.cas_n != 8'hFF && !REFRESH_BUSY && !$past(REFRESH_BUSY) |->
        PINS.ras_n != 8'hFF) else $error("column strobe without row");
    cover property (!PINS.flash_read_enable_n);
    cover property (REFRESH_BUSY && !SUSPEND_N);
    cover property (!PINS.extra_lsb_oe_n);
endmodule

bind mrp_mem_if mrp_chk i_chk (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .SUSPEND_N(SUSPEND_N), .PINS(PINS),
    .ROM_8BIT(ROM_8BIT), .REFRESH_BUSY(REFRESH_BUSY));

//--- sim/mrp_mem_if_tb.sv
// Purpose: Self-checking bench for the memory/ROM pin sequencer
// Assumes: Straps held steady through each reset
// Notes: Refresh cadence is only bounded, not timed exactly
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; $display("[ERR] %0t %h %h", $time, g, e); end end
module mrp_mem_if_tb;
    logic clk_sys = 0;
    logic rstn = 0;
    logic suspend_n = 1;
    logic rtc = 0;
    logic strap_fl = 1;
    logic strap_b0 = 1;
    logic req_ready, done, rom_8bit, rom_on_bus, ref_busy;
    logic [7:0] rd_check, check_in;
    logic [7:0] chk_mem [8];
    logic [63:0] rd_vld;
    mrp_pkg::mrp_req_t req = '0;
    mrp_pkg::mrp_pins_t pins;
    int failures = 0;
    int check_count = 0;
    always #4 clk_sys = ~clk_sys;
    mrp_mem_if i_dut (.CLK_SYS(clk_sys), .RSTN(rstn), .REQ(req), .REQ_READY(req_ready), .RD_CHECK_VALID(rd_vld),
        .RD_CHECK(rd_check), .DONE(done), .SUSPEND_N(suspend_n), .RTC(rtc), .CHECK_IN(check_in),
        .FLASH_STRAP_IN(strap_fl), .BANK0_STRAP_IN(strap_b0), .PINS(pins), .ROM_8BIT(rom_8bit),
        .ROM_ON_MEM_BUS(rom_on_bus), .REFRESH_BUSY(ref_busy));
    mrp_mem_model i_mem (.CLK_SYS(clk_sys), .PINS(pins), .CHECK_IN(check_in));
    task automatic results;
        if (failures == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic do_reset(input logic fl, input logic b0);
        @(posedge clk_sys);
        rstn <= 0;
        strap_fl <= fl;
        strap_b0 <= b0;
        repeat (4) @(posedge clk_sys);
        rstn <= 1;
        repeat (4) @(posedge clk_sys);
        `CHK(rom_8bit, fl)
        `CHK(rom_on_bus, b0)
    endtask
    task automatic send(input mrp_pkg::mrp_req_t r);
        int n;
        n = 0;
        @(posedge clk_sys);
        req <= r;
        do begin
            @(posedge clk_sys);
            n++;
        end while (req_ready !== 1'b1 && n < 2500);
        req <= '0;
        `CHK(req_ready, 1'b1)
        if (req_ready !== 1'b1) results;
    endtask
    task automatic wait_done;
        int n;
        for (n = 0; n < 40 && done !== 1'b1; n++)
            @(posedge clk_sys);
        `CHK(done, 1'b1)
        if (done !== 1'b1) results;
    endtask
    task automatic dram(input logic w, input logic [2:0] b, input logic [7:0] be, input logic [7:0] c);
        mrp_pkg::mrp_req_t r;
        int n;
        logic rs, cs;
        r = '0;
        r.valid = 1;
        r.write = w;
        r.bank = b;
        r.row = 13'h1A5A + 13'(b);
        r.col = 13'h0C3C - 13'(b);
        r.byte_en = be;
        r.wr_check = c;
        rs = 0;
        cs = 0;
        send(r);
        if (w) chk_mem[b] = c;
        for (n = 0; n < 40 && done !== 1'b1; n++) begin
            #1;
            if (pins.ras_n !== 8'hFF && !rs) begin
                rs = 1;
                `CHK(pins.ras_n, ~(8'h80 >> b))
                `CHK(pins.addr, r.row)
            end
            if (pins.cas_n !== 8'hFF && !cs) begin
                cs = 1;
                `CHK(pins.addr, r.col)
                `CHK(pins.cas_n, ~be)
                `CHK(pins.we_n, ~w)
                if (w) `CHK(pins.check_out, c)
                else `CHK({pins.read_latch_enable_n, pins.check_path_read_en_n}, 2'b00)
            end
            @(posedge clk_sys);
        end
        `CHK({rs, cs, done}, 3'b111)
        if (done !== 1'b1) results;
        `CHK(rd_vld, {63'h0, !w})
        if (!w) `CHK(rd_check, chk_mem[b])
    endtask
    task automatic rom(input mrp_pkg::mrp_kind_t k, input logic w, input logic [20:0] a);
        mrp_pkg::mrp_req_t r;
        logic b0;
        r = '0;
        r.valid = 1;
        r.kind = k;
        r.write = w;
        r.rom_addr = a;
        b0 = (k == mrp_pkg::MRP_K_ROM0);
        send(r);
        repeat (2) @(posedge clk_sys);
        #1;
        `CHK({pins.bank0_sel_n, pins.bank1_sel_n}, {!b0, b0})
        `CHK({pins.flash_read_enable_n, pins.we_n}, {w, !w})
        `CHK({pins.check_out, pins.addr[11:0]}, a[19:0])
        `CHK(pins.extra_lsb_oe_n, !(b0 && strap_fl))
        if (b0 && strap_fl) `CHK(pins.addr[12], a[20])
        `CHK(pins.buffer_dir_ctrl, w ? mrp_pkg::MRP_BUF_WRITE : mrp_pkg::MRP_BUF_READ)
        wait_done;
        @(posedge clk_sys);
        #1;
        `CHK({pins.flash_read_enable_n, pins.bank0_sel_n, pins.bank1_sel_n}, 3'b111)
    endtask
    task automatic suspend_test;
        mrp_pkg::mrp_req_t r;
        int n;
        int rises;
        logic was, took;
        r = '0;
        r.valid = 1;
        r.kind = mrp_pkg::MRP_K_ROM1;
        rises = 0;
        was = 0;
        took = 0;
        @(posedge clk_sys);
        suspend_n <= 0;
        repeat (4) @(posedge clk_sys);
        req <= r;
        for (n = 0; n < 400; n++) begin
            @(posedge clk_sys);
            rtc <= (n % 100) < 50;
            rises += int'(ref_busy && !was);
            was = ref_busy;
            took = took | req_ready;
        end
        `CHK(rises, 4)
        `CHK(took, 1'b0)
        suspend_n <= 1;
        send(r);
        wait_done;
    endtask
    initial begin
        do_reset(1'b1, 1'b1);
        suspend_test;
        dram(1'b1, 3'h0, 8'hFF, 8'hA5);
        dram(1'b1, 3'h7, 8'h81, 8'h3C);
        dram(1'b0, 3'h0, 8'hFF, 8'h00);
        dram(1'b0, 3'h7, 8'h0F, 8'h00);
        rom(mrp_pkg::MRP_K_ROM0, 1'b0, 21'h1ABCDE);
        rom(mrp_pkg::MRP_K_ROM0, 1'b1, 21'h054321);
        rom(mrp_pkg::MRP_K_ROM1, 1'b0, 21'h0F0F0F);
        rom(mrp_pkg::MRP_K_ROM1, 1'b1, 21'h1F00FF);
        do_reset(1'b0, 1'b0);
        rom(mrp_pkg::MRP_K_ROM0, 1'b0, 21'h15A5A5);
        for (int n = 0; n < 2100 && ref_busy !== 1'b1; n++)
            @(posedge clk_sys);
        `CHK(ref_busy, 1'b1)
        results;
    end
endmodule

//--- sim/mrp_mem_model.sv
// Purpose: Behavioural memory bank with buffered check-bit lane
// Assumes: One word of check bits per row-strobe pattern
// Notes: Released lane toggles every cycle so stale data cannot match
`timescale 1ns/1ps
module mrp_mem_model (
    input wire logic CLK_SYS,
    input wire mrp_pkg::mrp_pins_t PINS,
    output logic [7:0] CHECK_IN
);
    logic [7:0] mem [256];
    logic [7:0] last_reg = 8'h00;
    // Buffers fitted between bus and memory
    always_ff @(posedge CLK_SYS) begin
        if (PINS.cas_n != 8'hFF && !PINS.we_n && !PINS.check_oe_n)
            mem[PINS.ras_n] <= PINS.check_out;
        last_reg <= CHECK_IN;
    end
    assign CHECK_IN = (!PINS.check_path_read_en_n && PINS.cas_n != 8'hFF) ? mem[PINS.ras_n] : ~last_reg;
endmodule
